//--- pcsr_pkg.sv
// constants and carriers for the loop control and status registers
// assumes a single 40 MHz register clock shared by every user
package pcsr_pkg;

   // register addresses on the peripheral bus
   localparam logic [31:0] ADDR_CONTROL_HOLD = 32'he01fc080;
   localparam logic [31:0] ADDR_CONFIG_HOLD  = 32'he01fc084;
   localparam logic [31:0] ADDR_LIVE_STATUS  = 32'he01fc088;
   localparam logic [31:0] ADDR_UNLOCK_FEED  = 32'he01fc08c;

   // unlock sequence values
   localparam logic [7:0] FEED_FIRST  = 8'haa;
   localparam logic [7:0] FEED_SECOND = 8'h55;

   // reset values
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   localparam logic [6:0] CONFIG_RESET  = 7'h00;

   // field positions in control and configuration
   localparam int CTL_ON_BIT   = 0;
   localparam int CTL_SEL_BIT  = 1;
   localparam int MULT_LSB     = 0;
   localparam int MULT_W       = 5;
   localparam int DIV_LSB      = 5;
   localparam int DIV_W        = 2;
   localparam int CONFIG_W     = 7;

   // field positions in the status word
   localparam int STAT_ON_BIT   = 8;
   localparam int STAT_SEL_BIT  = 9;
   localparam int STAT_LOCK_BIT = 10;

   // idle cycles with both clock gates closed during a source change
   localparam int SWITCH_GAP = 2;

   // one register access, one bus cycle per clock
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } pcsr_req_s;

   // settings that drive the loop
   typedef struct packed {
      logic              on;
      logic              sel;
      logic [DIV_W-1:0]  div;
      logic [MULT_W-1:0] mult;
   } pcsr_live_s;

   // clock source switch states
   typedef enum logic [1:0] {
      SRC_OSC     = 2'b00,
      SRC_TO_LOOP = 2'b01,
      SRC_LOOP    = 2'b10,
      SRC_TO_OSC  = 2'b11
   } pcsr_src_e;

endpackage

//--- pcsr_top.sv
// holding, live and status registers of the clock loop, unlock feed
// logic and a break-before-make clock source selector
// assumes a one-cycle bus access, lock detect from the analogue loop
// on a foreign clock, and a power-down entry pulse on this clock
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - live enable turns loop on after unlock
// - loop clock only when enable and connect live
// - control writes wait for valid unlock
// - configuration writes wait for valid unlock
// - configuration bits 4:0 give multiplier
// - configuration bits 6:5 give post-divider
// - reserved bits unstored, software writes zero
// - status returns live multiplier and divider
// - status bit 8 live enable, power-down clears
// - status bit 9 live connect, power-down clears
// - status bit 10 shows lock
// - lock drives interrupt request line
// - connect without enable equals all off
// - enable alone runs loop on oscillator
// - source change is glitch-free
// - lock never gates connection
// - unlock is 0xaa then 0x55, consecutive
// - bad or split sequence applies nothing
// - multiplier field is multiplier minus one
// - divider codes 00..11 select 1,2,4,8
module pcsr_top #(
   parameter int GAP = pcsr_pkg::SWITCH_GAP
) (
   input  wire logic                clock,         // 40 MHz register clock
   input  wire logic                nrst,          // async reset, low
   input  wire pcsr_pkg::pcsr_req_s req,           // register access
   output logic [15:0]              rdata,         // read data, next cycle
   input  wire logic                power_down,    // power-down entry pulse
   input  wire logic                lock_detect,   // raw lock from loop
   output pcsr_pkg::pcsr_live_s     live,          // settings to the loop
   output logic                     lock_irq,      // lock interrupt request
   output logic                     osc_gate_en,   // oscillator clock gate
   output logic                     loop_gate_en   // loop clock gate
);

   ////////////////////////////////////////////////////////////////////
   // address decode
   logic wr_ctl;
   logic wr_cfg;
   logic wr_feed;
   logic rd_any;

   always_comb
   begin
      wr_ctl  = req.valid && req.write
                && req.addr == pcsr_pkg::ADDR_CONTROL_HOLD;
      wr_cfg  = req.valid && req.write
                && req.addr == pcsr_pkg::ADDR_CONFIG_HOLD;
      wr_feed = req.valid && req.write
                && req.addr == pcsr_pkg::ADDR_UNLOCK_FEED;
      rd_any  = req.valid && !req.write;
   end

   ////////////////////////////////////////////////////////////////////
   // lock detect synchroniser
   logic lock_s1;
   logic lock_s2;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
      end
      else
      begin
         lock_s1 <= lock_detect;
         lock_s2 <= lock_s1;
      end
   end

   // lock level straight to the interrupt controller
   assign lock_irq = lock_s2;

   ////////////////////////////////////////////////////////////////////
   // holding registers, feed tracking and live shadow
   logic [1:0]                    ctl_hold;
   logic [pcsr_pkg::CONFIG_W-1:0] cfg_hold;
   logic                          feed_armed;
   logic [1:0]                    next_ctl_hold;
   logic [pcsr_pkg::CONFIG_W-1:0] next_cfg_hold;
   logic                          next_feed_armed;
   pcsr_pkg::pcsr_live_s          next_live;
   logic                          feed_ok;

   always_comb
   begin
      next_ctl_hold = ctl_hold;
      next_cfg_hold = cfg_hold;
      next_live     = live;
      // only defined bits are kept
      if (wr_ctl)
         next_ctl_hold = req.wdata[1:0];
      if (wr_cfg)
         next_cfg_hold = req.wdata[pcsr_pkg::CONFIG_W-1:0];
      // second value must land on the very next cycle
      feed_ok = feed_armed && wr_feed
                && req.wdata == pcsr_pkg::FEED_SECOND;
      next_feed_armed = wr_feed
                && req.wdata == pcsr_pkg::FEED_FIRST;
      if (feed_ok)
      begin
         next_live.on   = ctl_hold[pcsr_pkg::CTL_ON_BIT];
         next_live.sel  = ctl_hold[pcsr_pkg::CTL_SEL_BIT];
         next_live.mult = cfg_hold[pcsr_pkg::MULT_LSB +:
                                   pcsr_pkg::MULT_W];
         next_live.div  = cfg_hold[pcsr_pkg::DIV_LSB +:
                                   pcsr_pkg::DIV_W];
      end
      // power-down turns off and disconnects, settings kept
      if (power_down)
      begin
         next_live.on  = 1'b0;
         next_live.sel = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ctl_hold   <= pcsr_pkg::CONTROL_RESET;
         cfg_hold   <= pcsr_pkg::CONFIG_RESET;
         feed_armed <= 1'b0;
         live       <= '0;
      end
      else
      begin
         ctl_hold   <= next_ctl_hold;
         cfg_hold   <= next_cfg_hold;
         feed_armed <= next_feed_armed;
         live       <= next_live;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data
   logic [15:0] next_rdata;

   always_comb
   begin
      next_rdata = rdata;
      if (rd_any)
      begin
         next_rdata = '0;
         case (req.addr)
            pcsr_pkg::ADDR_CONTROL_HOLD:
               next_rdata[1:0] = ctl_hold;
            pcsr_pkg::ADDR_CONFIG_HOLD:
               next_rdata[pcsr_pkg::CONFIG_W-1:0] = cfg_hold;
            pcsr_pkg::ADDR_LIVE_STATUS:
            begin
               next_rdata[pcsr_pkg::MULT_LSB +: pcsr_pkg::MULT_W] =
                  live.mult;
               next_rdata[pcsr_pkg::DIV_LSB +: pcsr_pkg::DIV_W] =
                  live.div;
               next_rdata[pcsr_pkg::STAT_ON_BIT]   = live.on;
               next_rdata[pcsr_pkg::STAT_SEL_BIT]  = live.sel;
               next_rdata[pcsr_pkg::STAT_LOCK_BIT] = lock_s2;
            end
            default:
               next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rdata <= '0;
      else
         rdata <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////
   // clock source selector, both gates closed for GAP cycles
   pcsr_pkg::pcsr_src_e src;
   pcsr_pkg::pcsr_src_e next_src;
   logic [7:0]          gap_cnt;
   logic [7:0]          next_gap_cnt;
   logic                want_loop;
   logic                gap_done;

   always_comb
   begin
      // connect alone counts as off; lock is not looked at
      want_loop    = live.on && live.sel;
      gap_done     = gap_cnt == 8'(GAP - 1);
      next_src     = src;
      next_gap_cnt = 8'h00;
      case (src)
         pcsr_pkg::SRC_OSC:
            if (want_loop)
               next_src = pcsr_pkg::SRC_TO_LOOP;
         pcsr_pkg::SRC_TO_LOOP:
            if (!want_loop)
               next_src = pcsr_pkg::SRC_TO_OSC;
            else if (gap_done)
               next_src = pcsr_pkg::SRC_LOOP;
            else
               next_gap_cnt = 8'(gap_cnt + 8'h01);
         pcsr_pkg::SRC_LOOP:
            if (!want_loop)
               next_src = pcsr_pkg::SRC_TO_OSC;
         pcsr_pkg::SRC_TO_OSC:
            if (gap_done)
               next_src = pcsr_pkg::SRC_OSC;
            else
               next_gap_cnt = 8'(gap_cnt + 8'h01);
         default:
            next_src = pcsr_pkg::SRC_OSC;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         src          <= pcsr_pkg::SRC_OSC;
         gap_cnt      <= 8'h00;
         osc_gate_en  <= 1'b1;
         loop_gate_en <= 1'b0;
      end
      else
      begin
         src          <= next_src;
         gap_cnt      <= next_gap_cnt;
         osc_gate_en  <= next_src == pcsr_pkg::SRC_OSC;
         loop_gate_en <= next_src == pcsr_pkg::SRC_LOOP;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence feed_pair_s;
      wr_feed && req.wdata == pcsr_pkg::FEED_FIRST
      ##1 wr_feed && req.wdata == pcsr_pkg::FEED_SECOND && !power_down;
   endsequence

   sequence loop_wanted_s;
      (live.on && live.sel)[*8];
   endsequence

   feed_apply_a: assert property (
      @(posedge clock) disable iff (!nrst)
      feed_pair_s |=> {live.div, live.mult} == $past(cfg_hold)
         && live.on == $past(ctl_hold[pcsr_pkg::CTL_ON_BIT])
         && live.sel == $past(ctl_hold[pcsr_pkg::CTL_SEL_BIT]))
      else $error("unlock pair did not load live settings");

   hold_isolated_a: assert property (
      @(posedge clock) disable iff (!nrst)
      !feed_ok && !power_down |=> $stable(live))
      else $error("live settings changed without unlock");

   power_down_a: assert property (
      @(posedge clock) disable iff (!nrst)
      power_down |=> !live.on && !live.sel)
      else $error("power-down left loop on or connected");

   status_read_a: assert property (
      @(posedge clock) disable iff (!nrst)
      rd_any && req.addr == pcsr_pkg::ADDR_LIVE_STATUS
      |=> rdata == {5'h00, $past(lock_s2), $past(live.sel),
                    $past(live.on), 1'b0, $past(live.div),
                    $past(live.mult)})
      else $error("status read mismatch");

   lock_irq_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lock_detect[*3] |=> lock_irq)
      else $error("lock not seen on interrupt line");

   gates_apart_a: assert property (
      @(posedge clock) disable iff (!nrst)
      !(osc_gate_en && loop_gate_en))
      else $error("both clock gates open");

   loop_only_both_a: assert property (
      @(posedge clock) disable iff (!nrst)
      !(live.on && live.sel) |=> !loop_gate_en)
      else $error("loop clock without enable and connect");

   loop_reached_a: assert property (
      @(posedge clock) disable iff (!nrst)
      loop_wanted_s |-> loop_gate_en)
      else $error("loop clock not selected");

   osc_kept_a: assert property (
      @(posedge clock) disable iff (!nrst)
      (live.on && !live.sel)[*8] |-> osc_gate_en && live.on)
      else $error("enable alone left oscillator clock");

endmodule
`default_nettype wire

//--- pcsr_loop_model.sv
// stand-in for the analogue loop: lock follows the live enable
// assumes live settings from the register block on the same clock
`timescale 1ns/100ps
`default_nettype none

module pcsr_loop_model #(
   parameter int LOCK_T = 16
) (
   input  wire logic                 clock,       // register clock
   input  wire logic                 nrst,        // async reset, low
   input  wire pcsr_pkg::pcsr_live_s live,        // loop settings
   output logic                      lock_detect  // raw lock, off the edge
);
   int cnt;

   // lock rises LOCK_T+1 cycles after enable, drops one cycle after it is off
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst || !live.on)
         cnt <= 0;
      else if (cnt < LOCK_T)
         cnt <= cnt + 1;
      lock_detect <= #3 (nrst && live.on && cnt == LOCK_T);
   end
endmodule

`default_nettype wire

//--- test_pcsr_top.sv
// self-checking bench for the loop control and status registers
// assumes the loop model drives lock and the bench acts as processor
`timescale 1ns/100ps
`default_nettype none

module test_pcsr_top;
   localparam logic [31:0] CTL = pcsr_pkg::ADDR_CONTROL_HOLD;
   localparam logic [31:0] CFG = pcsr_pkg::ADDR_CONFIG_HOLD;
   localparam logic [31:0] STA = pcsr_pkg::ADDR_LIVE_STATUS;
   localparam logic [31:0] FED = pcsr_pkg::ADDR_UNLOCK_FEED;
   logic                 clock      = 1'b0;
   logic                 nrst       = 1'b0;
   logic                 power_down = 1'b0;
   pcsr_pkg::pcsr_req_s  req        = '0;
   logic [15:0]          rdata;
   pcsr_pkg::pcsr_live_s live;
   logic                 lock_detect;
   logic                 lock_irq;
   logic                 osc_gate_en;
   logic                 loop_gate_en;
   logic [15:0]          expq[$];
   logic [31:0]          seed       = 32'h839d6354;
   logic [6:0]           cfg;
   logic [6:0]           cfg_live;
   logic                 taken      = 1'b0;
   int                   num_errors = 0;
   int                   n_tests    = 0;
   int                   cyc        = 0;
   int                   i;

   pcsr_top u_pcsr_top (.clock(clock), .nrst(nrst), .req(req),
      .rdata(rdata), .power_down(power_down), .lock_detect(lock_detect),
      .live(live), .lock_irq(lock_irq), .osc_gate_en(osc_gate_en),
      .loop_gate_en(loop_gate_en));
   pcsr_loop_model u_pcsr_loop_model (.clock(clock), .nrst(nrst),
      .live(live), .lock_detect(lock_detect));

   ////////////////////////////////////////////////////////////////////
   // clock and timeout
   always #12.5 clock = ~clock;

   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("FAIL %0t got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask

   task automatic close_out();
      if (num_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one bus cycle, driven just after the edge
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [7:0] d);
      req = '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(posedge clock);
      #1;
   endtask

   task automatic wait_cyc(input int n);
      req.valid = 1'b0;
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic rd(input logic [31:0] a, input logic [15:0] e);
      expq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask

   task automatic stat(input logic on, input logic sel, input logic lk);
      rd(STA, {5'h00, lk, sel, on, 1'b0, cfg_live});
   endtask

   task automatic feed();
      bus(1'b1, FED, pcsr_pkg::FEED_FIRST);
      bus(1'b1, FED, pcsr_pkg::FEED_SECOND);
      wait_cyc(1);
   endtask

   ////////////////////////////////////////////////////////////////////
   // read monitor: oldest note against rdata in the cycle after the read
   always @(posedge clock)
      taken <= req.valid & ~req.write;

   always @(negedge clock)
      if (taken === 1'b1)
      begin
         if (expq.size() == 0)
            chk(16'h0bad, 16'h0000);
         else
            chk(rdata, expq.pop_front());
      end

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (2) @(posedge clock);
      #1 nrst = 1'b1;
      cfg_live = 7'h00;
      chk({14'h0, osc_gate_en, loop_gate_en}, 16'h0002);
      rd(CTL, 16'h0000);
      rd(CFG, 16'h0000);
      stat(1'b0, 1'b0, 1'b0);
      rd(FED, 16'h0000);
      rd(32'he01fc090, 16'h0000);
      for (i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         cfg = {2'(i), seed[4:0]};
         bus(1'b1, CFG, {1'b0, cfg});
         rd(CFG, {9'h000, cfg});
         stat(1'b0, 1'b0, 1'b0);
         feed();
         cfg_live = cfg;
         stat(1'b0, 1'b0, 1'b0);
      end
      bus(1'b1, CTL, 8'h01);
      bus(1'b1, FED, 8'haa);
      wait_cyc(1);
      bus(1'b1, FED, 8'h55);
      bus(1'b1, FED, 8'haa);
      bus(1'b1, FED, 8'h56);
      bus(1'b1, FED, 8'h55);
      bus(1'b1, FED, 8'haa);
      bus(1'b1, FED, 8'haa);
      stat(1'b0, 1'b0, 1'b0);
      bus(1'b1, FED, 8'h55);
      stat(1'b0, 1'b0, 1'b0);
      feed();
      stat(1'b1, 1'b0, 1'b0);
      chk({14'h0, osc_gate_en, loop_gate_en}, 16'h0002);
      for (i = 0; i < 100 && lock_irq !== 1'b1; i++)
         wait_cyc(1);
      chk({15'h0, lock_irq}, 16'h0001);
      stat(1'b1, 1'b0, 1'b1);
      bus(1'b1, CTL, 8'h03);
      feed();
      wait_cyc(8);
      chk({14'h0, osc_gate_en, loop_gate_en}, 16'h0001);
      stat(1'b1, 1'b1, 1'b1);
      bus(1'b1, CTL, 8'h02);
      feed();
      wait_cyc(8);
      chk({14'h0, osc_gate_en, loop_gate_en}, 16'h0002);
      stat(1'b0, 1'b1, 1'b0);
      bus(1'b1, CTL, 8'h03);
      feed();
      wait_cyc(8);
      chk({14'h0, loop_gate_en, lock_irq}, 16'h0002);
      power_down = 1'b1;
      wait_cyc(1);
      power_down = 1'b0;
      wait_cyc(8);
      chk({14'h0, osc_gate_en, loop_gate_en}, 16'h0002);
      stat(1'b0, 1'b0, 1'b0);
      bus(1'b1, STA, 8'hff);
      bus(1'b1, 32'he01fc0a0, 8'hff);
      stat(1'b0, 1'b0, 1'b0);
      rd(CTL, 16'h0003);
      wait_cyc(4);
      chk(16'(expq.size()), 16'h0000);
      close_out();
   end
endmodule

`default_nettype wire
